// >>> rtl/ccrc_map.svh
// Purpose: offsets, field positions, reset values and selector codes of the crc engine
// Assumes: included by bare name from rtl files
// Notes:   definitions only
`ifndef CCRC_MAP_SVH
`define CCRC_MAP_SVH

// ----------------------------------------
// coprocessor selector codes
// ----------------------------------------
`define CCRC_SEL_LOAD_INIT      16'h0201
`define CCRC_SEL_LOAD_INIT_REV  16'h0211
`define CCRC_SEL_FOLD_BYTE      16'h0204
`define CCRC_SEL_FOLD_BYTE_REV  16'h0214
`define CCRC_SEL_FOLD_HALF      16'h0205
`define CCRC_SEL_FOLD_HALF_REV  16'h0215
`define CCRC_SEL_FOLD_DWORD     16'h1207
`define CCRC_SEL_FOLD_DWORD_REV 16'h1217
`define CCRC_SEL_LOAD_POLY      16'h4200
`define CCRC_SEL_LOAD_POLY_REV  16'h4210

// ----------------------------------------
// apb register offsets
// ----------------------------------------
`define CCRC_OFF_CTRL   12'h000
`define CCRC_OFF_VALUE  12'h004
`define CCRC_OFF_POLY   12'h008
`define CCRC_OFF_STAT   12'h00c
`define CCRC_OFF_IEN    12'h010
`define CCRC_OFF_ICLR   12'h014
`define CCRC_OFF_COUNT  12'h018

// ----------------------------------------
// control and status fields
// ----------------------------------------
`define CCRC_CTRL_CP2_EN  0
`define CCRC_CTRL_X64_EN  1
`define CCRC_CTRL_CRYPTO_DISABLE_FLAG 2
`define CCRC_EV_DONE      0
`define CCRC_EV_CPU       1
`define CCRC_EV_RSVD      2
`define CCRC_EV_UNKNOWN   3
`define CCRC_EV_W         4

// ----------------------------------------
// reset values
// ----------------------------------------
`define CCRC_RST_CTRL   3'h0
`define CCRC_RST_VALUE  32'h0000_0000
`define CCRC_RST_POLY   32'h04c1_1db7

`endif

// >>> rtl/ccrc_pkg.sv
// Purpose: types shared by the crc engine files
// Assumes: none
// Notes:   numbers live in ccrc_map.svh
package ccrc_pkg;

  // answer to an issued instruction
  typedef enum logic [1:0] {
    CCRC_RSP_OK,
    CCRC_RSP_CPU,
    CCRC_RSP_RSVD
  } ccrc_rsp_t;

  // instruction kind after decode
  typedef enum logic [2:0] {
    CCRC_OP_NONE,
    CCRC_OP_INIT,
    CCRC_OP_POLY,
    CCRC_OP_BYTE,
    CCRC_OP_HALF,
    CCRC_OP_DWORD
  } ccrc_op_t;

endpackage

// >>> rtl/ccrc_fold.sv
// Purpose: one-step combinational crc fold of up to eight bytes
// Assumes: bytes fed least significant first, msb of each byte first
// Notes:   nbytes selects how many low bytes fold in
`timescale 1ns/1ns
module ccrc_fold #(
  parameter int NB = 8
) (
  // operands
  input  wire logic [31:0]     crc_in,
  input  wire logic [31:0]     poly,
  input  wire logic [NB*8-1:0] data,
  input  wire logic [3:0]      nbytes,
  // result
  output logic      [31:0]     crc_out
);

  // ----------------------------------------
  // byte chain
  // ----------------------------------------
  function automatic logic [31:0] fold_byte(input logic [31:0] c, input logic [7:0] b, input logic [31:0] p);
    logic [31:0] r;
    r = c ^ {b, 24'h00_0000};
    for (int i = 0; i < 8; i++) begin
      r = r[31] ? ((r << 1) ^ p) : (r << 1);
    end
    return r;
  endfunction

  logic [31:0] stage [0:NB];
  assign stage[0] = crc_in;

  genvar g;
  generate
    for (g = 0; g < NB; g++) begin : g_byte
      assign stage[g+1] = (4'(g) < nbytes) ? fold_byte(stage[g], data[g*8 +: 8], poly) : stage[g];
    end
  endgenerate

  assign crc_out = stage[NB];

endmodule

// >>> rtl/ccrc_engine.sv
// Purpose: crc coprocessor engine with apb register view
// Assumes: core presents one instruction per cycle on issue_valid
// Notes:   answer follows issue by one cycle
//
// What this block does
// - byte selector folds low byte into value
// - reflected byte folds bit-reversed low byte
// - halfword selector folds low sixteen bits
// - reflected halfword reverses both bytes, then folds
// - doubleword selector folds all sixty-four bits
// - reflected doubleword reverses every byte first
// - reflection touches input only, not value/poly
// - initial load copies low 32 bits
// - reflected initial load stores byte-reversed bits
// - coprocessor disabled: unusable exception, no change
// - no 64-bit ops: reserved exception; crypto-off ignored
// - polynomial load copies low 32 bits
// - reflected polynomial load stores byte-reversed bits
`timescale 1ns/1ns
`include "ccrc_map.svh"
module ccrc_engine #(
  parameter int CNT_W = 32
) (
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // coprocessor issue
  input  wire logic                issue_valid,
  input  wire logic [15:0]         issue_sel,
  input  wire logic [63:0]         source_gpr_field,
  // coprocessor answer
  output logic                     rsp_valid,
  output ccrc_pkg::ccrc_rsp_t      rsp_code,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // interrupt
  output logic                     irq
);
  import ccrc_pkg::*;

  // ----------------------------------------
  // reflection helper
  // ----------------------------------------
  function automatic logic [63:0] reflect_bytes(input logic [63:0] v);
    logic [63:0] r;
    r = 64'h0;
    for (int b = 0; b < 8; b++) begin
      for (int i = 0; i < 8; i++) begin
        r[b*8+i] = v[b*8+7-i];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [31:0]            crc_running_value_q;
  logic [31:0]            crc_running_value_d;
  logic [31:0]            crc_polynomial_reg_q;
  logic [31:0]            crc_polynomial_reg_d;
  logic [2:0]             ctrl_q;
  logic [`CCRC_EV_W-1:0]  stat_q;
  logic [`CCRC_EV_W-1:0]  stat_d;
  logic [`CCRC_EV_W-1:0]  ien_q;
  logic [CNT_W-1:0]       count_q;
  logic                   rsp_valid_q;
  ccrc_rsp_t              rsp_code_q;
  logic [31:0]            prdata_q;
  logic                   pready_q;
  logic                   pslverr_q;
  logic                   irq_q;

  // ----------------------------------------
  // instruction decode
  // ----------------------------------------
  wire logic       cp2_en   = ctrl_q[`CCRC_CTRL_CP2_EN];
  wire logic       x64_en   = ctrl_q[`CCRC_CTRL_X64_EN];
  wire logic       sel_rev  = issue_sel[4];
  logic            known;
  ccrc_op_t        op;

  always_comb begin
    known = 1'b1;
    case (issue_sel)
      `CCRC_SEL_LOAD_INIT, `CCRC_SEL_LOAD_INIT_REV:   op = CCRC_OP_INIT;
      `CCRC_SEL_LOAD_POLY, `CCRC_SEL_LOAD_POLY_REV:   op = CCRC_OP_POLY;
      `CCRC_SEL_FOLD_BYTE, `CCRC_SEL_FOLD_BYTE_REV:   op = CCRC_OP_BYTE;
      `CCRC_SEL_FOLD_HALF, `CCRC_SEL_FOLD_HALF_REV:   op = CCRC_OP_HALF;
      `CCRC_SEL_FOLD_DWORD, `CCRC_SEL_FOLD_DWORD_REV: op = CCRC_OP_DWORD;
      default: begin
        op    = CCRC_OP_NONE;
        known = 1'b0;
      end
    endcase
  end

  // access checks; crypto-disable bit deliberately unused here
  wire logic exc_cpu  = issue_valid & known & ~cp2_en;
  wire logic exc_rsvd = issue_valid & known & cp2_en & ~x64_en;
  wire logic do_op    = issue_valid & known & cp2_en & x64_en;
  wire logic bad_sel  = issue_valid & ~known;

  // ----------------------------------------
  // datapath
  // ----------------------------------------
  wire logic [63:0] src_refl = reflect_bytes(source_gpr_field);
  wire logic [63:0] src_in   = sel_rev ? src_refl : source_gpr_field;
  logic [3:0]       nbytes;
  logic [31:0]      fold_out;

  always_comb begin
    case (op)
      CCRC_OP_BYTE:  nbytes = 4'h1;
      CCRC_OP_HALF:  nbytes = 4'h2;
      CCRC_OP_DWORD: nbytes = 4'h8;
      default:       nbytes = 4'h0;
    endcase
  end

  ccrc_fold #(
    .NB (8)
  ) u_fold (
    .crc_in  (crc_running_value_q),
    .poly    (crc_polynomial_reg_q),
    .data    (src_in),
    .nbytes  (nbytes),
    .crc_out (fold_out)
  );

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  wire logic apb_acc = psel & penable & ~pready_q;
  wire logic apb_wr  = apb_acc & pwrite;
  wire logic apb_rd  = apb_acc & ~pwrite;
  wire logic hit_ctrl  = (paddr == `CCRC_OFF_CTRL);
  wire logic hit_value = (paddr == `CCRC_OFF_VALUE);
  wire logic hit_poly  = (paddr == `CCRC_OFF_POLY);
  wire logic hit_stat  = (paddr == `CCRC_OFF_STAT);
  wire logic hit_ien   = (paddr == `CCRC_OFF_IEN);
  wire logic hit_iclr  = (paddr == `CCRC_OFF_ICLR);
  wire logic hit_count = (paddr == `CCRC_OFF_COUNT);
  wire logic mapped    = hit_ctrl | hit_value | hit_poly | hit_stat | hit_ien | hit_iclr | hit_count;
  // value, poly, stat and count are read-only to software; writes refused
  wire logic wr_ro     = apb_wr & (hit_value | hit_poly | hit_stat | hit_count);

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (hit_ctrl) begin
      rd_mux = {29'h0, ctrl_q};
    end else if (hit_value) begin
      rd_mux = crc_running_value_q;
    end else if (hit_poly) begin
      rd_mux = crc_polynomial_reg_q;
    end else if (hit_stat) begin
      rd_mux = {{(32-`CCRC_EV_W){1'b0}}, stat_q};
    end else if (hit_ien) begin
      rd_mux = {{(32-`CCRC_EV_W){1'b0}}, ien_q};
    end else if (hit_count) begin
      rd_mux = 32'(count_q);
    end
  end

  // ----------------------------------------
  // next values
  // ----------------------------------------
  always_comb begin
    crc_running_value_d  = crc_running_value_q;
    crc_polynomial_reg_d = crc_polynomial_reg_q;
    if (do_op) begin
      case (op)
        CCRC_OP_INIT:  crc_running_value_d  = src_in[31:0];
        CCRC_OP_POLY:  crc_polynomial_reg_d = src_in[31:0];
        CCRC_OP_BYTE, CCRC_OP_HALF, CCRC_OP_DWORD: crc_running_value_d = fold_out;
        default: ;
      endcase
    end
  end

  // sticky events: set wins over a same-cycle clear
  logic [`CCRC_EV_W-1:0] ev_set;
  logic [`CCRC_EV_W-1:0] ev_clr;
  always_comb begin
    ev_set = '0;
    ev_set[`CCRC_EV_DONE]    = do_op;
    ev_set[`CCRC_EV_CPU]     = exc_cpu;
    ev_set[`CCRC_EV_RSVD]    = exc_rsvd;
    ev_set[`CCRC_EV_UNKNOWN] = bad_sel;
    ev_clr = (apb_wr & hit_iclr) ? pwdata[`CCRC_EV_W-1:0] : '0;
    stat_d = (stat_q & ~ev_clr) | ev_set;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc_running_value_q  <= `CCRC_RST_VALUE;
      crc_polynomial_reg_q <= `CCRC_RST_POLY;
      stat_q               <= '0;
      count_q              <= '0;
    end else begin
      crc_running_value_q  <= crc_running_value_d;
      crc_polynomial_reg_q <= crc_polynomial_reg_d;
      stat_q               <= stat_d;
      if (do_op) begin
        count_q <= count_q + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CCRC_RST_CTRL;
      ien_q  <= '0;
    end else if (apb_wr & hit_ctrl) begin
      ctrl_q <= pwdata[2:0];
    end else if (apb_wr & hit_ien) begin
      ien_q  <= pwdata[`CCRC_EV_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_valid_q <= 1'b0;
      rsp_code_q  <= CCRC_RSP_OK;
    end else begin
      rsp_valid_q <= issue_valid;
      rsp_code_q  <= exc_cpu ? CCRC_RSP_CPU : ((exc_rsvd | bad_sel) ? CCRC_RSP_RSVD : CCRC_RSP_OK);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      pready_q  <= apb_acc;
      pslverr_q <= apb_acc & (~mapped | wr_ro);
      prdata_q  <= (apb_rd & mapped) ? rd_mux : 32'h0;
      irq_q     <= |(stat_d & ien_q);
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp_code  = rsp_code_q;
  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign irq       = irq_q;

endmodule

// >>> tb/ccrc_engine_checker.sv
// Purpose: port assertions for the crc engine
// Assumes: bound into every ccrc_engine
// Notes:   issue and apb timing
`timescale 1ns/1ns
module ccrc_engine_checker #(
  parameter int CNT_W = 32
) (
  // clock and reset
  input wire logic           pclk,
  input wire logic           presetn,
  // issue
  input wire logic           issue_valid,
  input wire logic [15:0]    issue_sel,
  input wire logic [63:0]    source_gpr_field,
  input wire logic           rsp_valid,
  input ccrc_pkg::ccrc_rsp_t rsp_code,
  // apb
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [11:0]    paddr,
  input wire logic [31:0]    pwdata,
  input wire logic [31:0]    prdata,
  input wire logic           pready,
  input wire logic           pslverr,
  input wire logic           irq
);
  import ccrc_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_rsp_next; issue_valid |=> rsp_valid; endproperty
  a_rsp_next: assert property (p_rsp_next) else $error("no answer");
  property p_rsp_cause; rsp_valid |-> $past(issue_valid); endproperty
  a_rsp_cause: assert property (p_rsp_cause) else $error("stray answer");
  property p_bad_sel; issue_valid && issue_sel[3:0] == 4'h9 |=> rsp_code == CCRC_RSP_RSVD || rsp_code == CCRC_RSP_CPU;
  endproperty
  a_bad_sel: assert property (p_bad_sel) else $error("odd selector ok");
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("late pready");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("long pready");
  property p_rd_idle; !pready |-> prdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("prdata idle");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("lone pslverr");
  property p_unmapped; psel && penable && !pready && paddr > 12'h018 |=> pslverr && prdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped ok");
endmodule
bind ccrc_engine ccrc_engine_checker #(.CNT_W(CNT_W)) i_chk (.*);

// >>> tb/ccrc_core_model.sv
// Purpose: core side issuing coprocessor moves
// Assumes: answer comes one cycle after issue
// Notes:   source bus inverted when idle
`timescale 1ns/1ns
module ccrc_core_model (
  // clock
  input wire logic           pclk,
  // issue
  output logic               issue_valid,
  output logic [15:0]        issue_sel,
  output logic [63:0]        source_gpr_field,
  // answer
  input wire logic           rsp_valid,
  input ccrc_pkg::ccrc_rsp_t rsp_code
);
  import ccrc_pkg::*;
  initial begin
    issue_valid = 1'b0;
    issue_sel = 16'h0;
    source_gpr_field = 64'h0;
  end
  // one move; code 7 means no answer
  task automatic issue(input logic [15:0] s, input logic [63:0] d, output logic [2:0] r);
    @(posedge pclk);
    issue_valid <= 1'b1;
    issue_sel <= s;
    source_gpr_field <= d;
    @(posedge pclk);
    issue_valid <= 1'b0;
    source_gpr_field <= ~d;
    @(posedge pclk);
    r = rsp_valid ? {1'b0, rsp_code} : 3'h7;
  endtask
endmodule

// >>> tb/tb_ccrc_engine.sv
// Purpose: self-checking bench for the crc engine
// Assumes: 250 MHz pclk
// Notes:   expected crc from a bitwise model
`timescale 1ns/1ns
`include "ccrc_map.svh"
module tb_ccrc_engine;
  import ccrc_pkg::*;
  logic pclk, presetn, issue_valid, rsp_valid, psel, penable, pwrite, pready, pslverr, irq;
  logic [15:0] issue_sel;
  logic [63:0] source_gpr_field;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, ev, ep;
  ccrc_rsp_t   rsp_code;
  int          fails, check_count, n_ok;
  ccrc_engine i_dut (.pclk, .presetn, .issue_valid, .issue_sel, .source_gpr_field, .rsp_valid, .rsp_code,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);
  ccrc_core_model i_core (.pclk, .issue_valid, .issue_sel, .source_gpr_field, .rsp_valid, .rsp_code);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  function automatic logic [7:0] rv8(logic [7:0] b);
    for (int i = 0; i < 8; i++) rv8[i] = b[7-i];
  endfunction
  function automatic logic [31:0] rv32(logic [31:0] w);
    for (int i = 0; i < 4; i++) rv32[8*i+:8] = rv8(w[8*i+:8]);
  endfunction
  function automatic logic [31:0] fold(logic [31:0] c, logic [63:0] d, int n, bit f);
    logic [7:0] b;
    for (int i = 0; i < n; i++) begin
      b = f ? rv8(d[8*i+:8]) : d[8*i+:8];
      c = c ^ {b, 24'h0};
      for (int k = 0; k < 8; k++) c = c[31] ? (c << 1) ^ ep : c << 1;
    end
    return c;
  endfunction
  function automatic void upd(logic [15:0] s, logic [63:0] d);
    case (s)
      `CCRC_SEL_LOAD_INIT:      ev = d[31:0];
      `CCRC_SEL_LOAD_INIT_REV:  ev = rv32(d[31:0]);
      `CCRC_SEL_FOLD_BYTE:      ev = fold(ev, d, 1, 0);
      `CCRC_SEL_FOLD_BYTE_REV:  ev = fold(ev, d, 1, 1);
      `CCRC_SEL_FOLD_HALF:      ev = fold(ev, d, 2, 0);
      `CCRC_SEL_FOLD_HALF_REV:  ev = fold(ev, d, 2, 1);
      `CCRC_SEL_FOLD_DWORD:     ev = fold(ev, d, 8, 0);
      `CCRC_SEL_FOLD_DWORD_REV: ev = fold(ev, d, 8, 1);
      `CCRC_SEL_LOAD_POLY:      ep = d[31:0];
      `CCRC_SEL_LOAD_POLY_REV:  ep = rv32(d[31:0]);
      default: ;
    endcase
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  // apb transfer; read data and error taken at the pready edge
  task automatic acc(logic w, logic [11:0] a, logic [31:0] d, logic ee);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("pready wait", 32'h2, 32'(n));
    if (!w) chk("prdata", d, prdata);
    chk("pslverr", {31'h0, ee}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic op(logic [15:0] s, logic [63:0] d, logic [2:0] ec);
    logic [2:0] r;
    i_core.issue(s, d, r);
    chk("rsp_code", {29'h0, ec}, {29'h0, r});
    if (ec == 3'h0) begin
      upd(s, d);
      n_ok++;
    end
    acc(1'b0, `CCRC_OFF_VALUE, ev, 1'b0);
    acc(1'b0, `CCRC_OFF_POLY, ep, 1'b0);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic t_refuse();
    acc(1'b0, 12'hffc, 32'h0, 1'b1);
    acc(1'b1, `CCRC_OFF_VALUE, 32'h1, 1'b1);
    op(`CCRC_SEL_FOLD_BYTE, 64'ha5, 3'h1);
    acc(1'b1, `CCRC_OFF_CTRL, 32'h5, 1'b0);
    op(`CCRC_SEL_LOAD_INIT, 64'h1234, 3'h2);
    acc(1'b1, `CCRC_OFF_CTRL, 32'h3, 1'b0);
    op(16'h0209, 64'h77, 3'h2);
    acc(1'b0, `CCRC_OFF_STAT, 32'he, 1'b0);
    $display("refusal test done");
  endtask
  task automatic t_ops();
    logic [15:0] s[11] = '{`CCRC_SEL_LOAD_POLY_REV, `CCRC_SEL_LOAD_INIT_REV, `CCRC_SEL_FOLD_BYTE,
      `CCRC_SEL_FOLD_BYTE_REV, `CCRC_SEL_FOLD_HALF, `CCRC_SEL_FOLD_HALF_REV, `CCRC_SEL_FOLD_DWORD,
      `CCRC_SEL_FOLD_DWORD_REV, `CCRC_SEL_LOAD_POLY, `CCRC_SEL_LOAD_INIT, `CCRC_SEL_FOLD_HALF};
    logic [63:0] d[11] = '{64'h1_0471_8823, 64'h9_8001_c0f1, 64'hff_ff3c, 64'h01, 64'h55_80e7,
      64'h0102, 64'h0123_4567_89ab_cdef, 64'hfedc_ba98_7654_3210, 64'h1021_0000, 64'hffff_0000, 64'h3132};
    acc(1'b1, `CCRC_OFF_CTRL, 32'h7, 1'b0);
    for (int i = 0; i < 11; i++) op(s[i], d[i], 3'h0);
    $display("operation test done");
  endtask
  task automatic t_irq();
    acc(1'b1, `CCRC_OFF_ICLR, 32'hf, 1'b0);
    acc(1'b1, `CCRC_OFF_IEN, 32'h1, 1'b0);
    acc(1'b0, `CCRC_OFF_IEN, 32'h1, 1'b0);
    op(`CCRC_SEL_FOLD_BYTE, 64'h3c, 3'h0);
    chk("irq", 32'h1, {31'h0, irq});
    acc(1'b1, `CCRC_OFF_ICLR, 32'h1, 1'b0);
    acc(1'b0, `CCRC_OFF_STAT, 32'h0, 1'b0);
    chk("irq", 32'h0, {31'h0, irq});
    acc(1'b1, `CCRC_OFF_IEN, 32'h0, 1'b0);
    op(`CCRC_SEL_FOLD_BYTE, 64'h3d, 3'h0);
    chk("irq", 32'h0, {31'h0, irq});
    acc(1'b0, `CCRC_OFF_COUNT, 32'(n_ok), 1'b0);
    $display("interrupt test done");
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    stop_test();
  end
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    ev = `CCRC_RST_VALUE;
    ep = `CCRC_RST_POLY;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    acc(1'b0, `CCRC_OFF_POLY, ep, 1'b0);
    t_refuse();
    t_ops();
    t_irq();
    stop_test();
  end
endmodule
